// ===== hw/port_tag_status_diag_regs.v
`timescale 1ns/1ps
`include "port_tag_status_diag_regs_consts.vh"
module port_tag_status_diag_regs
(
   input wire CLK,
   input wire SYS_RST,
   input wire REG_WR,
   input wire REG_RD,
   input wire [7:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   output reg [7:0] REG_RDATA,
   output wire [63:0] DEFAULT_TAGS,
   output wire PORT4_REDUCED_MII_CLK_OE,
   output wire [1:0] CROSSOVER_SCHEME_SELECT,
   input wire [1:0] POL_REVERSED,
   input wire [1:0] TX_FLOW_ACTIVE,
   input wire [1:0] RX_FLOW_ACTIVE,
   input wire [1:0] SPEED_100,
   input wire [1:0] FULL_DUPLEX,
   output wire [1:0] CABLE_TEST_START,
   input wire [1:0] CABLE_TEST_DONE,
   input wire [1:0] NEAR_SHORT_FLAG,
   input wire [3:0] CABLE_RESULT,
   input wire [17:0] FAULT_COUNT
);
   reg [7:0] vid_lo_q [0:3];
   reg [7:0] tag_hi_q [0:3];
   reg clk_dis_q;
   reg [1:0] xover_q;
   // results of the two cable test engines, held until the next completion
   wire [1:0] test_busy;
   wire [1:0] near_short;
   wire [3:0] cable_res;
   wire [17:0] fault_cnt;
   // second-stage copies of everything that arrives from the PHY domain
   wire [9:0] link_st;
   wire [1:0] done_st;
   wire [23:0] res_st;
   // a write to a diag register with the test enable bit set
   wire [1:0] start_hit;
   integer i;

   // link levels cross in two flops so reads never see a metastable bit;
   // each bit is an independent level, so no word coherence is needed
   bit_sync #
   (
      .WIDTH(10)
   )
   link_sync
   (
      .clk(CLK),
      .din({POL_REVERSED, TX_FLOW_ACTIVE, RX_FLOW_ACTIVE, SPEED_100,
            FULL_DUPLEX}),
      .dout_q(link_st)
   );

   // completion levels from the cable test engines
   bit_sync #
   (
      .WIDTH(2)
   )
   done_sync
   (
      .clk(CLK),
      .din(CABLE_TEST_DONE),
      .dout_q(done_st)
   );

   // the engine holds its results steady before raising done, and done is
   // itself two flops late, so this word has settled when it is latched
   bit_sync #
   (
      .WIDTH(24)
   )
   result_sync
   (
      .clk(CLK),
      .din({NEAR_SHORT_FLAG, CABLE_RESULT, FAULT_COUNT}),
      .dout_q(res_st)
   );

   // software arms a test by writing the enable bit of its diag register
   assign start_hit[0] = REG_WR && REG_WDATA[`BIT_TEST_EN] &&
                         (REG_ADDR == `OFS_P1_DIAG);
   assign start_hit[1] = REG_WR && REG_WDATA[`BIT_TEST_EN] &&
                         (REG_ADDR == `OFS_P2_DIAG);

   // one handshake per PHY port; port 1 takes the low half of each bus
   cable_test_slot port1_test
   (
      .clk(CLK),
      .rst(SYS_RST),
      .start(start_hit[0]),
      .done(done_st[0]),
      .near_in(res_st[22]),
      .result_in(res_st[19:18]),
      .fault_in(res_st[8:0]),
      .busy(test_busy[0]),
      .near_q(near_short[0]),
      .result_q(cable_res[1:0]),
      .fault_q(fault_cnt[8:0])
   );

   cable_test_slot port2_test
   (
      .clk(CLK),
      .rst(SYS_RST),
      .start(start_hit[1]),
      .done(done_st[1]),
      .near_in(res_st[23]),
      .result_in(res_st[21:20]),
      .fault_in(res_st[17:9]),
      .busy(test_busy[1]),
      .near_q(near_short[1]),
      .result_q(cable_res[3:2]),
      .fault_q(fault_cnt[17:9])
   );

   // writable registers; the cable test handshake is in cable_test_slot
   always @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         for (i = 0; i < 4; i = i + 1)
         begin
            vid_lo_q[i] <= `RST_VID_LO;
            tag_hi_q[i] <= `RST_TAG_HI;
         end
         clk_dis_q <= `RST_CLK_DIS;
         xover_q <= {2{`RST_XOVER}};
      end
      else
      begin
         if (REG_WR)
         begin
            case (REG_ADDR)
               `OFS_P1_VID_LO: vid_lo_q[0] <= REG_WDATA;
               `OFS_P2_VID_LO: vid_lo_q[1] <= REG_WDATA;
               `OFS_P3_VID_LO: vid_lo_q[2] <= REG_WDATA;
               `OFS_P4_VID_LO: vid_lo_q[3] <= REG_WDATA;
               `OFS_P1_TAG_HI: tag_hi_q[0] <= REG_WDATA;
               `OFS_P2_TAG_HI: tag_hi_q[1] <= REG_WDATA;
               `OFS_P3_TAG_HI: tag_hi_q[2] <= REG_WDATA;
               `OFS_P4_TAG_HI: tag_hi_q[3] <= REG_WDATA;
               // only bit 3 is stored; reserved bits drop writes
               `OFS_RMII_CTRL: clk_dis_q <= REG_WDATA[`BIT_CLK_DIS];
               `OFS_P1_LINK: xover_q[0] <= REG_WDATA[`BIT_XOVER];
               `OFS_P2_LINK: xover_q[1] <= REG_WDATA[`BIT_XOVER];
               default: ;
            endcase
         end
      end
   end

   // read mux; reserved and unmapped bits read zero
   // the data holds between reads, so a slow master may fetch it late
   always @(posedge CLK)
   begin
      if (SYS_RST)
         REG_RDATA <= 8'h00;
      else if (REG_RD)
      begin
         case (REG_ADDR)
            `OFS_P1_VID_LO: REG_RDATA <= vid_lo_q[0];
            `OFS_P2_VID_LO: REG_RDATA <= vid_lo_q[1];
            `OFS_P3_VID_LO: REG_RDATA <= vid_lo_q[2];
            `OFS_P4_VID_LO: REG_RDATA <= vid_lo_q[3];
            `OFS_P1_TAG_HI: REG_RDATA <= tag_hi_q[0];
            `OFS_P2_TAG_HI: REG_RDATA <= tag_hi_q[1];
            `OFS_P3_TAG_HI: REG_RDATA <= tag_hi_q[2];
            `OFS_P4_TAG_HI: REG_RDATA <= tag_hi_q[3];
            `OFS_RMII_CTRL: REG_RDATA <= {4'h0, clk_dis_q, 3'h0};
            // bits: xover, 0, pol, txfc, rxfc, speed, duplex, 0
            `OFS_P1_LINK: REG_RDATA <= {xover_q[0], 1'b0, link_st[8],
               link_st[6], link_st[4], link_st[2], link_st[0], 1'b0};
            `OFS_P2_LINK: REG_RDATA <= {xover_q[1], 1'b0, link_st[9],
               link_st[7], link_st[5], link_st[3], link_st[1], 1'b0};
            `OFS_P1_DIAG: REG_RDATA <= {near_short[0], cable_res[1:0],
               test_busy[0], 3'h0, fault_cnt[8]};
            `OFS_P2_DIAG: REG_RDATA <= {near_short[1], cable_res[3:2],
               test_busy[1], 3'h0, fault_cnt[17]};
            `OFS_P1_FAULT_LO: REG_RDATA <= fault_cnt[7:0];
            `OFS_P2_FAULT_LO: REG_RDATA <= fault_cnt[16:9];
            default: REG_RDATA <= 8'h00;
         endcase
      end
   end

   // tags: {priority, cfi, vid[11:8], vid[7:0]} per port, port 1 lowest
   assign DEFAULT_TAGS = {tag_hi_q[3], vid_lo_q[3], tag_hi_q[2], vid_lo_q[2],
                          tag_hi_q[1], vid_lo_q[1], tag_hi_q[0], vid_lo_q[0]};
   assign PORT4_REDUCED_MII_CLK_OE = ~clk_dis_q;
   assign CROSSOVER_SCHEME_SELECT = xover_q;
   assign CABLE_TEST_START = test_busy;
endmodule

// two-flop synchroniser; only the second stage may be read downstream
// no reset: the chain flushes itself within two clocks anyway
module bit_sync
#(
   parameter WIDTH = 1
)
(
   input wire clk,
   input wire [WIDTH-1:0] din,
   output reg [WIDTH-1:0] dout_q
);
   reg [WIDTH-1:0] meta_q;

   // the first stage may go metastable; nothing but dout_q reads it
   always @(posedge clk)
   begin
      meta_q <= din;
      dout_q <= meta_q;
   end
endmodule

// one cable test handshake: software arms it, the engine's done ends it
module cable_test_slot
(
   input wire clk,
   input wire rst,
   input wire start,
   input wire done,
   input wire near_in,
   input wire [1:0] result_in,
   input wire [8:0] fault_in,
   output wire busy,
   output reg near_q,
   output reg [1:0] result_q,
   output reg [8:0] fault_q
);
   localparam IDLE = 2'b01;
   localparam RUN = 2'b10;
   reg [1:0] state_q;
   reg [1:0] state_d;

   // done beats a same-cycle start so a finished test is not rearmed
   always @*
   begin
      state_d = state_q;
      case (state_q)
         IDLE:
         begin
            if (start)
               state_d = RUN;
         end
         RUN:
         begin
            if (done)
               state_d = IDLE;
         end
         default: state_d = IDLE;
      endcase
   end

   // results are captured only on the edge that closes a run, so a stray
   // done while idle cannot overwrite the last valid outcome
   always @(posedge clk)
   begin
      if (rst)
      begin
         state_q <= IDLE;
         near_q <= `RST_NEAR;
         result_q <= `RST_RESULT;
         fault_q <= `RST_FAULT;
      end
      else
      begin
         state_q <= state_d;
         if (state_q == RUN && done)
         begin
            near_q <= near_in;
            result_q <= result_in;
            fault_q <= fault_in;
         end
      end
   end

   // busy reads back as the self-clearing test enable bit
   assign busy = state_q[1];
endmodule

// ===== hw/port_tag_status_diag_regs_consts.vh
`ifndef PORT_TAG_STATUS_DIAG_REGS_CONSTS_VH
`define PORT_TAG_STATUS_DIAG_REGS_CONSTS_VH
// register offsets on the management register port
`define OFS_P1_VID_LO 8'h24
`define OFS_P1_TAG_HI 8'h23
`define OFS_P1_LINK 8'h29
`define OFS_P1_DIAG 8'h2A
`define OFS_P1_FAULT_LO 8'h2B
`define OFS_P2_VID_LO 8'h34
`define OFS_P2_TAG_HI 8'h33
`define OFS_P2_LINK 8'h39
`define OFS_P2_DIAG 8'h3A
`define OFS_P2_FAULT_LO 8'h3B
`define OFS_P3_VID_LO 8'h44
`define OFS_P3_TAG_HI 8'h43
`define OFS_P4_VID_LO 8'h54
`define OFS_P4_TAG_HI 8'h53
`define OFS_RMII_CTRL 8'h57
// reset values
`define RST_VID_LO 8'h01
`define RST_TAG_HI 8'h00
`define RST_XOVER 1'b1
`define RST_CLK_DIS 1'b0
`define RST_NEAR 1'b0
`define RST_RESULT 2'h0
`define RST_FAULT 9'h000
// field positions
`define BIT_CLK_DIS 3
`define BIT_XOVER 7
`define BIT_TEST_EN 4
`endif

// ===== bench/tag_regs_monitor.sv
`timescale 1ns/1ps
module tag_regs_monitor
(
   input wire CLK,
   input wire SYS_RST,
   input wire REG_WR,
   input wire REG_RD,
   input wire [7:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   input wire [7:0] REG_RDATA,
   input wire [63:0] DEFAULT_TAGS,
   input wire PORT4_REDUCED_MII_CLK_OE,
   input wire [1:0] CROSSOVER_SCHEME_SELECT,
   input wire [1:0] SPEED_100,
   input wire [1:0] FULL_DUPLEX,
   input wire [1:0] CABLE_TEST_START,
   input wire [1:0] CABLE_TEST_DONE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   chk_vid_write:
   assert property (REG_WR && REG_ADDR == 8'h24 |=>
      DEFAULT_TAGS[7:0] == $past(REG_WDATA)) else $error("vid lost");
   chk_clk_gate:
   assert property (REG_WR && REG_ADDR == 8'h57 |=> PORT4_REDUCED_MII_CLK_OE
      == !$past(REG_WDATA[3])) else $error("clock gate wrong");
   chk_xover_write:
   assert property (REG_WR && REG_ADDR == 8'h29 |=>
      CROSSOVER_SCHEME_SELECT[0] == $past(REG_WDATA[7])) else $error("xover");
   chk_test_start:
   assert property (REG_WR && REG_ADDR == 8'h2A && REG_WDATA[4] &&
      !CABLE_TEST_START[0] |=> CABLE_TEST_START[0]) else $error("no start");
   chk_test_clear:
   assert property ($rose(CABLE_TEST_DONE[0]) && CABLE_TEST_START[0] |->
      ##3 !CABLE_TEST_START[0]) else $error("start not cleared");
   // speed and duplex must follow the pins once they settle
   chk_link_live:
   assert property (($stable(SPEED_100[0]) && $stable(FULL_DUPLEX[0]))[*4]
      ##0 REG_RD && REG_ADDR == 8'h29 |=> REG_RDATA[2:1] ==
      {$past(SPEED_100[0]), $past(FULL_DUPLEX[0])}) else $error("link");
   chk_unmapped_zero:
   assert property (REG_RD && REG_ADDR == 8'h00 |=> REG_RDATA == 8'h00)
      else $error("unmapped read");
   chk_rmii_read:
   assert property (REG_RD && REG_ADDR == 8'h57 |=> REG_RDATA ==
      {4'h0, !$past(PORT4_REDUCED_MII_CLK_OE), 3'h0}) else $error("rmii");
endmodule
bind port_tag_status_diag_regs tag_regs_monitor mon
(
   .CLK(CLK), .SYS_RST(SYS_RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
   .DEFAULT_TAGS(DEFAULT_TAGS),
   .PORT4_REDUCED_MII_CLK_OE(PORT4_REDUCED_MII_CLK_OE),
   .CROSSOVER_SCHEME_SELECT(CROSSOVER_SCHEME_SELECT),
   .SPEED_100(SPEED_100), .FULL_DUPLEX(FULL_DUPLEX),
   .CABLE_TEST_START(CABLE_TEST_START), .CABLE_TEST_DONE(CABLE_TEST_DONE)
);

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   reg CLK = 1'b0, SYS_RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0;
   reg [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00;
   reg [1:0] POL_REVERSED = 2'h0, TX_FLOW_ACTIVE = 2'h0, RX_FLOW_ACTIVE = 2'h0;
   reg [1:0] SPEED_100 = 2'h0, FULL_DUPLEX = 2'h0, CABLE_TEST_DONE = 2'h0;
   reg [1:0] NEAR_SHORT_FLAG = 2'h0;
   reg [3:0] CABLE_RESULT = 4'h0;
   reg [17:0] FAULT_COUNT = {9'h000, 9'h15A};
   wire [7:0] REG_RDATA;
   wire [63:0] DEFAULT_TAGS;
   wire PORT4_REDUCED_MII_CLK_OE;
   wire [1:0] CROSSOVER_SCHEME_SELECT, CABLE_TEST_START;
   integer fails = 0, n_compared = 0, i, k;
   port_tag_status_diag_regs dut
   (
      .CLK(CLK), .SYS_RST(SYS_RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
      .DEFAULT_TAGS(DEFAULT_TAGS),
      .PORT4_REDUCED_MII_CLK_OE(PORT4_REDUCED_MII_CLK_OE),
      .CROSSOVER_SCHEME_SELECT(CROSSOVER_SCHEME_SELECT),
      .POL_REVERSED(POL_REVERSED), .TX_FLOW_ACTIVE(TX_FLOW_ACTIVE),
      .RX_FLOW_ACTIVE(RX_FLOW_ACTIVE), .SPEED_100(SPEED_100),
      .FULL_DUPLEX(FULL_DUPLEX), .CABLE_TEST_START(CABLE_TEST_START),
      .CABLE_TEST_DONE(CABLE_TEST_DONE), .NEAR_SHORT_FLAG(NEAR_SHORT_FLAG),
      .CABLE_RESULT(CABLE_RESULT), .FAULT_COUNT(FAULT_COUNT)
   );
   always #10 CLK = ~CLK;
   task chk(input [63:0] got, input [63:0] exp);
   begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
         fails = fails + 1;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   end
   endtask
   // one strobe cycle; the idle edge first keeps strobes from re-driving
   task acc(input w, input [7:0] a, input [7:0] d);
   begin
      @(posedge CLK) #1;
      {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {w, !w, a, d};
      @(posedge CLK) #1;
      {REG_WR, REG_RD} = 2'h0;
   end
   endtask
   task rc(input [7:0] a, input [7:0] e);
   begin
      acc(1'b0, a, 8'h00);
      chk(REG_RDATA, e);
   end
   endtask
   // arm one cable test, answer done, and time the self-clear
   task run_test(input [7:0] a, input [1:0] m);
   begin
      acc(1'b1, a, 8'h10);
      @(posedge CLK) #1 chk(CABLE_TEST_START, m);
      CABLE_TEST_DONE = m;
      for (i = 0; i < 20 && (CABLE_TEST_START & m) !== 2'h0; i = i + 1)
         @(posedge CLK) #1;
      chk(i, 3);
      if (i == 20)
         finish_test;
      CABLE_TEST_DONE = 2'h0;
   end
   endtask
   // status pins pass a two-flop synchroniser, so let them settle
   task link(input [1:0] v);
   begin
      {POL_REVERSED, TX_FLOW_ACTIVE, RX_FLOW_ACTIVE} = {v, v, v};
      {SPEED_100, FULL_DUPLEX} = {v, v};
      repeat (3) @(posedge CLK);
   end
   endtask
   task finish_test;
   begin
      $display("compared %0d wrong %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask
   initial
   begin
      repeat (20) @(posedge CLK);
      #1 SYS_RST = 1'b0;
      for (i = 0; i < 4; i = i + 1)
         rc(8'h24 + {i[3:0], 4'h0}, 8'h01);
      rc(8'h57, 8'h00);
      rc(8'h29, 8'h80);
      rc(8'h00, 8'h00);
      acc(1'b1, 8'h54, 8'hAA);
      acc(1'b1, 8'h53, 8'hE5);
      chk(DEFAULT_TAGS[63:48], 16'hE5AA);
      chk(DEFAULT_TAGS[15:0], 16'h0001);
      rc(8'h53, 8'hE5);
      acc(1'b1, 8'h57, 8'hFF);
      chk(PORT4_REDUCED_MII_CLK_OE, 1'b0);
      rc(8'h57, 8'h08);
      $display("register test done");
      acc(1'b1, 8'h29, 8'h7F);
      acc(1'b1, 8'h39, 8'h00);
      chk(CROSSOVER_SCHEME_SELECT, 2'h0);
      rc(8'h29, 8'h00);
      link(2'h1);
      rc(8'h29, 8'h3E);
      rc(8'h39, 8'h00);
      link(2'h2);
      rc(8'h29, 8'h00);
      rc(8'h39, 8'h3E);
      $display("link test done");
      @(posedge CLK) #1 SYS_RST = 1'b1;
      repeat (3) @(posedge CLK);
      #1 SYS_RST = 1'b0;
      rc(8'h54, 8'h01);
      rc(8'h53, 8'h00);
      rc(8'h57, 8'h00);
      rc(8'h39, 8'hBE);
      $display("reset test done");
      for (k = 0; k < 4; k = k + 1)
      begin
         {NEAR_SHORT_FLAG, CABLE_RESULT} = {1'b0, k[0], 2'h0, k[1:0]};
         run_test(8'h2A, 2'h1);
         rc(8'h2A, {k[0], k[1:0], 5'h01});
         rc(8'h2B, 8'h5A);
      end
      FAULT_COUNT = {9'h0A5, 9'h15A};
      {NEAR_SHORT_FLAG, CABLE_RESULT} = 6'h2C;
      run_test(8'h3A, 2'h2);
      rc(8'h3A, 8'hE0);
      rc(8'h3B, 8'hA5);
      rc(8'h2A, 8'hE1);
      $display("cable test done");
      finish_test;
   end
endmodule
